// ---- test_trap_and_vector_logic.sv ----
// Self-checking bench for the trap and vector logic.
`default_nettype none
module test_trap_and_vector_logic;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [9:0] trap_cond_in = 10'h000;
    logic [3:0] ext_req_in = 4'h0;
    logic eop_req_in = 1'b0;
    logic cpu_ack_in, svc_done_in, irq_out, a;
    logic [7:0] s_awaddr_in = 8'h00, s_araddr_in = 8'h00, seg = 8'h00;
    logic [31:0] s_wdata_in = 32'h0, s_rdata_out, rd;
    logic [3:0] s_wstrb_in = 4'hf, ack_wait = 4'h0;
    logic s_awvalid_in = 0, s_wvalid_in = 0, s_bready_in = 0;
    logic s_arvalid_in = 0, s_rready_in = 0, hold_svc = 0;
    logic s_awready_out, s_wready_out, s_bvalid_out;
    logic s_arready_out, s_rvalid_out;
    logic [1:0] s_bresp_out, s_rresp_out, rsp;
    tvl_pkg::tvl_branch_t branch_out;
    logic [7:0] taken_cnt;
    logic [6:0] last_num;
    logic [23:0] last_addr;
    int n_errors = 0, comparisons = 0;
    logic [6:0] trap_tn [10] = '{tvl_pkg::TN_SR0, tvl_pkg::TN_STACK_OVERFLOW_FLAG,
        tvl_pkg::TN_STACK_UNDERFLOW_FLAG, tvl_pkg::TN_SBRK, tvl_pkg::TN_CLASS_B,
        tvl_pkg::TN_CLASS_B, tvl_pkg::TN_CLASS_B, tvl_pkg::TN_CLASS_B,
        tvl_pkg::TN_CLASS_B, tvl_pkg::TN_CLASS_B};
    logic [6:0] req_tn [5] = '{tvl_pkg::TN_ERU0, tvl_pkg::TN_ERU1,
        tvl_pkg::TN_ERU2, tvl_pkg::TN_ERU3, tvl_pkg::TN_EOP};
    // 10 MHz clock
    always #50 core_clk_in = ~core_clk_in;
    tvl_top dut (.*);
    tvl_cpu_model cpu (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .branch_in(branch_out), .hold_svc_in(hold_svc),
        .ack_wait_in(ack_wait), .cpu_ack_out(cpu_ack_in),
        .svc_done_out(svc_done_in), .taken_cnt_out(taken_cnt),
        .last_num_out(last_num), .last_addr_out(last_addr));
    // Compare and count
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("%0d comparisons, %0d mismatches", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Write master: address and data together, each released when taken
    task automatic bus_write(input logic [7:0] ad, input logic [31:0] d);
        s_awaddr_in <= ad;
        s_wdata_in <= d;
        s_awvalid_in <= 1'b1;
        s_wvalid_in <= 1'b1;
        s_bready_in <= 1'b1;
        forever begin
            @(posedge core_clk_in);
            if (s_awvalid_in && s_awready_out) s_awvalid_in <= 1'b0;
            if (s_wvalid_in && s_wready_out) s_wvalid_in <= 1'b0;
            if (s_bvalid_out && s_bready_in) begin
                // Response ready stays high so back-to-back calls never
                // lower and raise it in one time step
                rsp = s_bresp_out;
                break;
            end
        end
    endtask
    task automatic bus_read(input logic [7:0] ad);
        s_araddr_in <= ad;
        s_arvalid_in <= 1'b1;
        s_rready_in <= 1'b1;
        forever begin
            @(posedge core_clk_in);
            if (s_arvalid_in && s_arready_out) s_arvalid_in <= 1'b0;
            if (s_rvalid_out && s_rready_in) begin
                rd = s_rdata_out;
                rsp = s_rresp_out;
                break;
            end
        end
    endtask
    task automatic pulse_trap(input int b);
        trap_cond_in <= 10'h001 << b;
        @(posedge core_clk_in);
        trap_cond_in <= 10'h000;
    endtask
    // Bounded wait for the CPU model to take branch number n
    task automatic await_branch(input logic [7:0] n);
        int t;
        t = 0;
        while (taken_cnt !== n && t < 60) begin
            @(posedge core_clk_in);
            t++;
        end
        check("branches taken", 32'(taken_cnt), 32'(n));
    endtask
    function automatic logic [23:0] vec_addr(input logic [6:0] num,
                                             input logic [1:0] code);
        return {seg, 16'(num) << (2 + code)};
    endfunction
    initial begin
        repeat (3) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        bus_read(tvl_pkg::OFS_CPU_CTRL);
        check("spacing reset", rd, 32'h0);
        bus_read(tvl_pkg::OFS_TRAP_FLAG);
        check("flags reset", rd, 32'h0);
        bus_read(tvl_pkg::OFS_IRQ_MASK);
        check("mask reset", rd, 32'h0);
        bus_read(8'h18);
        check("unmapped read", {rd[29:0], rsp}, 32'h2);
        bus_write(8'h1c, 32'h1);
        check("unmapped write", 32'(rsp), 32'h2);
        seg = 8'h5a;
        bus_write(tvl_pkg::OFS_VEC_SEG, 32'(seg));
        bus_read(tvl_pkg::OFS_VEC_SEG);
        check("segment", rd, 32'(seg));
        $display("test registers done");
        // Every trap, with prompt and slow CPU answers
        for (int i = 0; i < tvl_pkg::NUM_TRAPS; i++) begin
            ack_wait <= 4'(i % 3 * 3);
            pulse_trap(i);
            await_branch(8'(i + 1));
            check("trap number", 32'(last_num), 32'(trap_tn[i]));
            check("trap vector", 32'(last_addr), 32'(vec_addr(trap_tn[i], 0)));
            bus_read(tvl_pkg::OFS_TRAP_FLAG);
            check("trap flag", rd, 32'h1 << i);
            bus_write(tvl_pkg::OFS_TRAP_FLAG, 32'h1 << i);
        end
        $display("test traps done");
        // All four spacing codes
        for (int c = 0; c < 4; c++) begin
            bus_write(tvl_pkg::OFS_CPU_CTRL, 32'(c));
            pulse_trap(tvl_pkg::FLG_SBRK);
            await_branch(8'(11 + c));
            check("spaced vector", 32'(last_addr), 32'(vec_addr(tvl_pkg::TN_SBRK, 2'(c))));
        end
        bus_write(tvl_pkg::OFS_CPU_CTRL, 32'h0);
        bus_write(tvl_pkg::OFS_TRAP_FLAG, 32'h3ff);
        $display("test spacing done");
        for (int r = 0; r < 5; r++) begin
            if (r < 4) ext_req_in <= 4'h1 << r;
            else eop_req_in <= 1'b1;
            @(posedge core_clk_in);
            ext_req_in <= 4'h0;
            eop_req_in <= 1'b0;
            await_branch(8'(15 + r));
            check("request number", 32'(last_num), 32'(req_tn[r]));
            check("request vector", 32'(last_addr), 32'(vec_addr(req_tn[r], 0)));
            check("reserved slot", 32'(last_num[6:2] == 5'h19), 32'h0);
        end
        $display("test requests done");
        // Request waits behind a trap service; a higher trap preempts it
        hold_svc <= 1'b1;
        pulse_trap(tvl_pkg::FLG_UNDOP);
        await_branch(8'd20);
        ext_req_in <= 4'h1;
        @(posedge core_clk_in);
        ext_req_in <= 4'h0;
        repeat (10) @(posedge core_clk_in);
        check("request held off", 32'(taken_cnt), 32'd20);
        pulse_trap(tvl_pkg::FLG_SR0);
        await_branch(8'd21);
        check("preempting trap", 32'(last_num), 32'(tvl_pkg::TN_SR0));
        hold_svc <= 1'b0;
        await_branch(8'd22);
        check("deferred request", 32'(last_num), 32'(tvl_pkg::TN_ERU0));
        $display("test preemption done");
        // Interrupt line follows the mask; status clears by writing ones
        bus_read(tvl_pkg::OFS_TRAP_DONE);
        check("event status", rd, 32'h3);
        bus_write(tvl_pkg::OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge core_clk_in);
        a = irq_out;
        bus_write(tvl_pkg::OFS_IRQ_MASK, 32'h3);
        repeat (2) @(posedge core_clk_in);
        check("irq follows mask", 32'(a ^ irq_out), 32'h1);
        bus_write(tvl_pkg::OFS_TRAP_DONE, 32'h3);
        repeat (2) @(posedge core_clk_in);
        check("irq cleared", 32'(irq_out), 32'h0);
        bus_read(tvl_pkg::OFS_TRAP_DONE);
        check("status cleared", rd, 32'h0);
        $display("test interrupt done");
        give_verdict();
    end
    // Watchdog: the tests need well under 2000 cycles
    initial begin
        #3000000;
        n_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire

// ---- tvl_cpu_model.sv ----
// Behavioural model of the CPU core that takes branches to vectors.
`default_nettype none
module tvl_cpu_model (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Branch request and bench controls
    input wire tvl_pkg::tvl_branch_t branch_in,
    input wire logic hold_svc_in,
    input wire logic [3:0] ack_wait_in,
    // Handshake back to the block
    output logic cpu_ack_out,
    output logic svc_done_out,
    // Record of the branches taken
    output logic [7:0] taken_cnt_out,
    output logic [6:0] last_num_out,
    output logic [23:0] last_addr_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_ff;
    logic in_svc_ff;
    // Stall each branch a while, then hold service until the bench lets go
    always @(posedge core_clk_in) begin
        cpu_ack_out <= 1'b0;
        svc_done_out <= 1'b0;
        if (rst_in) begin
            wait_ff <= 4'h0;
            in_svc_ff <= 1'b0;
            taken_cnt_out <= 8'h00;
            last_num_out <= 7'h00;
            last_addr_out <= 24'h000000;
        end else if (branch_in.valid && !cpu_ack_out) begin
            if (wait_ff < ack_wait_in) begin
                wait_ff <= wait_ff + 4'h1;
            end else begin
                wait_ff <= 4'h0;
                cpu_ack_out <= 1'b1;
                in_svc_ff <= 1'b1;
                taken_cnt_out <= taken_cnt_out + 8'h01;
                last_num_out <= branch_in.trap_num;
                last_addr_out <= branch_in.addr;
            end
        end else if (in_svc_ff && !hold_svc_in) begin
            // One return closes nested services as well
            svc_done_out <= 1'b1;
            in_svc_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- tvl_pkg.sv ----
// Package for the trap and vector logic: offsets, codes, layouts.
`default_nettype none
package tvl_pkg;
    // AXI4-Lite register byte offsets
    localparam logic [7:0] OFS_TRAP_FLAG = 8'h00;
    localparam logic [7:0] OFS_VEC_SEG = 8'h04;
    localparam logic [7:0] OFS_CPU_CTRL = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_TRAP_DONE = 8'h14;
    // Trap flag bit positions
    localparam int FLG_SR0 = 0;
    localparam int FLG_STACK_OVERFLOW_FLAG = 1;
    localparam int FLG_STACK_UNDERFLOW_FLAG = 2;
    localparam int FLG_SBRK = 3;
    localparam int FLG_SR1 = 4;
    localparam int FLG_MPROT = 5;
    localparam int FLG_UNDOP = 6;
    localparam int FLG_ACCERR = 7;
    localparam int FLG_PRTF = 8;
    localparam int FLG_ILLOP = 9;
    localparam int NUM_TRAPS = 10;
    // Trap numbers
    localparam logic [6:0] TN_SR0 = 7'h02;
    localparam logic [6:0] TN_STACK_OVERFLOW_FLAG = 7'h04;
    localparam logic [6:0] TN_STACK_UNDERFLOW_FLAG = 7'h06;
    localparam logic [6:0] TN_SBRK = 7'h08;
    localparam logic [6:0] TN_CLASS_B = 7'h0a;
    localparam logic [6:0] TN_ERU0 = 7'h68;
    localparam logic [6:0] TN_ERU1 = 7'h69;
    localparam logic [6:0] TN_ERU2 = 7'h6a;
    localparam logic [6:0] TN_ERU3 = 7'h6d;
    localparam logic [6:0] TN_EOP = 7'h6f;
    localparam logic [6:0] TN_RSV_LO = 7'h64;
    localparam logic [6:0] TN_RSV_HI = 7'h67;
    // Reset values
    localparam logic [7:0] RST_VEC_SEG = 8'h00;
    localparam logic [2:0] RST_SPACING = 3'h0;
    localparam logic [15:0] RST_MASK = 16'h0000;
    // Vector spacing codes: 0=4 bytes (default), 1=8, 2=16, 3=32 bytes
    localparam logic [2:0] SPC_SHIFT_BASE = 3'h2;
    // Interrupt-status event bits
    localparam int EV_TRAP = 0;
    localparam int EV_IRQ = 1;
    localparam int NUM_EV = 2;
    // Branch request carried to the CPU core
    typedef struct packed {
        logic valid;
        logic is_trap;
        logic [6:0] trap_num;
        logic [23:0] addr;
    } tvl_branch_t;
endpackage
`default_nettype wire

// ---- tvl_top.sv ----
// Trap flags, vector table addressing and branch requests to the CPU.
`default_nettype none
module tvl_top (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Trap conditions, one pulse per occurrence, bit order of flags
    input wire logic [9:0] trap_cond_in,
    // Ordinary requests: external 0..3, end of event subchannel
    input wire logic [3:0] ext_req_in,
    input wire logic eop_req_in,
    // CPU handshake: branch taken, service return
    input wire logic cpu_ack_in,
    input wire logic svc_done_in,
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr_in,
    input wire logic s_awvalid_in,
    output logic s_awready_out,
    input wire logic [31:0] s_wdata_in,
    input wire logic [3:0] s_wstrb_in,
    input wire logic s_wvalid_in,
    output logic s_wready_out,
    output logic [1:0] s_bresp_out,
    output logic s_bvalid_out,
    input wire logic s_bready_in,
    input wire logic [7:0] s_araddr_in,
    input wire logic s_arvalid_in,
    output logic s_arready_out,
    output logic [31:0] s_rdata_out,
    output logic [1:0] s_rresp_out,
    output logic s_rvalid_out,
    input wire logic s_rready_in,
    // Branch request to CPU and interrupt line
    output tvl_pkg::tvl_branch_t branch_out,
    output logic irq_out
);
    typedef enum logic [2:0] {
        TVL_IDLE = 3'b001,
        TVL_TRAP = 3'b010,
        TVL_INTR = 3'b100
    } tvl_state_t;

    tvl_state_t state_ff, nxt_state;
    tvl_pkg::tvl_branch_t br_ff, nxt_br;
    logic [9:0] flag_ff, nxt_flag;
    logic [7:0] seg_ff, nxt_seg;
    logic [2:0] spc_ff, nxt_spc;
    logic [15:0] mask_ff, nxt_mask;
    logic [1:0] ists_ff, nxt_ists;
    logic [1:0] act_pri_ff, nxt_act_pri;
    logic [4:0] pend_ff, nxt_pend;
    logic irq_ff, nxt_irq;
    logic aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r;
    logic [7:0] awa_ff, nxt_awa;
    logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    // Ready flags kept in flops so every output leaves a register
    logic awr_ff, wrdy_ff, arr_ff;

    // Vector address: segment base plus number scaled by spacing
    function automatic logic [23:0] vec_addr(input logic [7:0] seg,
        input logic [2:0] spc, input logic [6:0] num);
        logic [15:0] ofs;
        ofs = 16'({9'h000, num} << (tvl_pkg::SPC_SHIFT_BASE + spc[1:0]));
        vec_addr = {seg, ofs};
    endfunction

    // Trap priority: 3 for SR0, 2 for other class A, 1 for class B
    function automatic logic [1:0] trap_pri(input logic [9:0] c);
        if (c[tvl_pkg::FLG_SR0]) trap_pri = 2'h3;
        else if (|c[3:1]) trap_pri = 2'h2;
        else if (|c[9:4]) trap_pri = 2'h1;
        else trap_pri = 2'h0;
    endfunction

    logic [1:0] new_pri;
    logic [6:0] trap_num;
    logic [6:0] irq_num;
    logic wr_go, rd_go;
    logic [9:0] w1c;

    always_comb begin
        new_pri = trap_pri(trap_cond_in);
        // Class A numbers own their vectors; class B shares one
        // class A numbering
        if (trap_cond_in[tvl_pkg::FLG_SR0]) trap_num = tvl_pkg::TN_SR0;
        else if (trap_cond_in[tvl_pkg::FLG_STACK_OVERFLOW_FLAG]) trap_num = tvl_pkg::TN_STACK_OVERFLOW_FLAG;
        else if (trap_cond_in[tvl_pkg::FLG_STACK_UNDERFLOW_FLAG]) trap_num = tvl_pkg::TN_STACK_UNDERFLOW_FLAG;
        else if (trap_cond_in[tvl_pkg::FLG_SBRK]) trap_num = tvl_pkg::TN_SBRK;
        else trap_num = tvl_pkg::TN_CLASS_B;
        // 64..67 never appear in this table
        if (pend_ff[0]) irq_num = tvl_pkg::TN_ERU0;
        else if (pend_ff[1]) irq_num = tvl_pkg::TN_ERU1;
        else if (pend_ff[2]) irq_num = tvl_pkg::TN_ERU2;
        else if (pend_ff[3]) irq_num = tvl_pkg::TN_ERU3;
        else irq_num = tvl_pkg::TN_EOP;
    end

    // Branch sequencer; traps need no enable, so they are non-maskable
    always_comb begin
        nxt_state = state_ff;
        nxt_br = br_ff;
        nxt_act_pri = act_pri_ff;
        nxt_pend = pend_ff | {eop_req_in, ext_req_in};
        if (br_ff.valid && cpu_ack_in) nxt_br.valid = 1'b0;
        if (new_pri != 2'h0 &&
            (state_ff != TVL_TRAP || new_pri > act_pri_ff)) begin
            nxt_state = TVL_TRAP;
            nxt_act_pri = new_pri;
            nxt_br.valid = 1'b1;
            nxt_br.is_trap = 1'b1;
            nxt_br.trap_num = trap_num;
            nxt_br.addr = vec_addr(seg_ff, spc_ff, trap_num);
        end else if (svc_done_in && state_ff != TVL_IDLE) begin
            nxt_state = TVL_IDLE;
            nxt_act_pri = 2'h0;
        // ordinary requests held off during traps
        end else if (state_ff == TVL_IDLE && |pend_ff && !br_ff.valid) begin
            nxt_state = TVL_INTR;
            nxt_br.valid = 1'b1;
            nxt_br.is_trap = 1'b0;
            nxt_br.trap_num = irq_num;
            nxt_br.addr = vec_addr(seg_ff, spc_ff, irq_num);
            nxt_pend = pend_ff & ~(5'h01 << 3'(irq_num == tvl_pkg::TN_ERU0 ? 0
                : irq_num == tvl_pkg::TN_ERU1 ? 1
                : irq_num == tvl_pkg::TN_ERU2 ? 2
                : irq_num == tvl_pkg::TN_ERU3 ? 3 : 4))
                | {eop_req_in, ext_req_in};
        end
    end

    // AXI4-Lite slave: write when address and data both held
    always_comb begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_awa = awa_ff;
        nxt_wd = wd_ff;
        nxt_b = b_ff;
        nxt_bresp = bresp_ff;
        nxt_r = r_ff;
        nxt_rd = rd_ff;
        nxt_rresp = rresp_ff;
        if (s_awvalid_in && !aw_ff && !b_ff) begin
            nxt_aw = 1'b1;
            nxt_awa = s_awaddr_in;
        end
        if (s_wvalid_in && !w_ff && !b_ff) begin
            nxt_w = 1'b1;
            nxt_wd = s_wdata_in;
        end
        wr_go = aw_ff && w_ff && !b_ff;
        if (wr_go) begin
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
            nxt_b = 1'b1;
            nxt_bresp = 2'b00;
            if (awa_ff > tvl_pkg::OFS_TRAP_DONE || awa_ff[1:0] != 2'b00)
                nxt_bresp = 2'b10;
        end
        if (b_ff && s_bready_in) nxt_b = 1'b0;
        rd_go = s_arvalid_in && !r_ff;
        if (rd_go) begin
            nxt_r = 1'b1;
            nxt_rresp = 2'b00;
            unique case (s_araddr_in)
                tvl_pkg::OFS_TRAP_FLAG: nxt_rd = {22'h0, flag_ff};
                tvl_pkg::OFS_VEC_SEG: nxt_rd = {24'h0, seg_ff};
                tvl_pkg::OFS_CPU_CTRL: nxt_rd = {29'h0, spc_ff};
                tvl_pkg::OFS_IRQ_MASK: nxt_rd = {16'h0, mask_ff};
                tvl_pkg::OFS_STATUS: nxt_rd = {27'h0, act_pri_ff, state_ff};
                tvl_pkg::OFS_TRAP_DONE: nxt_rd = {30'h0, ists_ff};
                default: begin
                    nxt_rd = 32'h0000_0000;
                    nxt_rresp = 2'b10;
                end
            endcase
        end
        if (r_ff && s_rready_in) nxt_r = 1'b0;
    end

    // Registers; hardware set wins over software clear
    always_comb begin
        nxt_seg = seg_ff;
        nxt_spc = spc_ff;
        nxt_mask = mask_ff;
        w1c = 10'h000;
        if (wr_go && s_wstrb_in != 4'h0) begin
            unique case (awa_ff)
                tvl_pkg::OFS_TRAP_FLAG: w1c = wd_ff[9:0];
                tvl_pkg::OFS_VEC_SEG: nxt_seg = wd_ff[7:0];
                tvl_pkg::OFS_CPU_CTRL: nxt_spc = wd_ff[2:0];
                tvl_pkg::OFS_IRQ_MASK: nxt_mask = wd_ff[15:0];
                default: ;
            endcase
        end
        nxt_flag = (flag_ff & ~w1c) | trap_cond_in;
        nxt_ists = ists_ff;
        if (wr_go && awa_ff == tvl_pkg::OFS_TRAP_DONE)
            nxt_ists = ists_ff & ~wd_ff[1:0];
        nxt_ists[tvl_pkg::EV_TRAP] = nxt_ists[tvl_pkg::EV_TRAP] | (|trap_cond_in);
        nxt_ists[tvl_pkg::EV_IRQ] = nxt_ists[tvl_pkg::EV_IRQ]
            | (|{eop_req_in, ext_req_in});
        nxt_irq = |(nxt_ists & mask_ff[1:0]);
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_ff <= TVL_IDLE;
            br_ff <= '0;
            act_pri_ff <= 2'h0;
            pend_ff <= 5'h00;
            flag_ff <= 10'h000;
            seg_ff <= tvl_pkg::RST_VEC_SEG;
            spc_ff <= tvl_pkg::RST_SPACING;
            mask_ff <= tvl_pkg::RST_MASK;
            ists_ff <= 2'h0;
            irq_ff <= 1'b0;
            awr_ff <= 1'b1;
            wrdy_ff <= 1'b1;
            arr_ff <= 1'b1;
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            b_ff <= 1'b0;
            r_ff <= 1'b0;
            awa_ff <= 8'h00;
            wd_ff <= 32'h0000_0000;
            rd_ff <= 32'h0000_0000;
            bresp_ff <= 2'b00;
            rresp_ff <= 2'b00;
        end else begin
            state_ff <= nxt_state;
            br_ff <= nxt_br;
            act_pri_ff <= nxt_act_pri;
            pend_ff <= nxt_pend;
            flag_ff <= nxt_flag;
            seg_ff <= nxt_seg;
            spc_ff <= nxt_spc;
            mask_ff <= nxt_mask;
            ists_ff <= nxt_ists;
            irq_ff <= nxt_irq;
            awr_ff <= !nxt_aw && !nxt_b;
            wrdy_ff <= !nxt_w && !nxt_b;
            arr_ff <= !nxt_r;
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            b_ff <= nxt_b;
            r_ff <= nxt_r;
            awa_ff <= nxt_awa;
            wd_ff <= nxt_wd;
            rd_ff <= nxt_rd;
            bresp_ff <= nxt_bresp;
            rresp_ff <= nxt_rresp;
        end
    end

    // Outputs straight from flip-flops
    assign s_awready_out = awr_ff;
    assign s_wready_out = wrdy_ff;
    assign s_bvalid_out = b_ff;
    assign s_bresp_out = bresp_ff;
    assign s_arready_out = arr_ff;
    assign s_rvalid_out = r_ff;
    assign s_rdata_out = rd_ff;
    assign s_rresp_out = rresp_ff;
    assign branch_out = br_ff;
    assign irq_out = irq_ff;

    // Trap condition raises its flag next edge
    AST_FLAG_SET: assert property (@(posedge core_clk_in) disable iff (rst_in)
        trap_cond_in[tvl_pkg::FLG_UNDOP] |=> flag_ff[tvl_pkg::FLG_UNDOP])
        else $error("trap flag not set");
    AST_TRAP_BRANCH: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (trap_cond_in != 10'h0 && state_ff == TVL_IDLE) |=>
        (br_ff.valid && br_ff.is_trap && state_ff == TVL_TRAP))
        else $error("trap did not branch");
    AST_NO_INT_IN_TRAP: assert property (@(posedge core_clk_in)
        disable iff (rst_in) (state_ff == TVL_TRAP) |=>
        !(br_ff.valid && !br_ff.is_trap && !$past(br_ff.valid)))
        else $error("interrupt entered during trap");
    AST_CLASS_B_NUM: assert property (@(posedge core_clk_in)
        disable iff (rst_in) (trap_cond_in == 10'h040 && state_ff == TVL_IDLE)
        |=> br_ff.trap_num == tvl_pkg::TN_CLASS_B)
        else $error("class b number wrong");
    AST_SR0_NUM: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (trap_cond_in[0] && state_ff == TVL_IDLE) |=> br_ff.trap_num == 7'h02)
        else $error("class a number wrong");
    AST_NO_RSV: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !(br_ff.valid && br_ff.trap_num >= tvl_pkg::TN_RSV_LO
        && br_ff.trap_num <= tvl_pkg::TN_RSV_HI))
        else $error("reserved vector requested");
    AST_ADDR: assert property (@(posedge core_clk_in) disable iff (rst_in)
        br_ff.valid |-> br_ff.addr == {seg_ff,
        16'({9'h0, br_ff.trap_num} << (2 + spc_ff[1:0]))})
        else $error("vector address wrong");
    AST_PREEMPT: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_ff == TVL_TRAP && act_pri_ff == 2'h1 && trap_cond_in[0])
        |=> act_pri_ff == 2'h3)
        else $error("higher trap did not preempt");
endmodule
`default_nettype wire
